// ==== pkg/dsl_consts.vh ====
// Constants for the debug serial autobaud link
`ifndef DSL_CONSTS_VH
`define DSL_CONSTS_VH

// Baud measurement
`define DSL_AUTOBAUD_BITS 8
`define DSL_MAX_DIV 512
`define DSL_MEAS_W 13
`define DSL_BIT_W 10

// Break detection and response
`define DSL_BREAK_BITS 9
`define DSL_BREAK_CHARS 4
`define DSL_CHAR_BITS 10

// Sync character
`define DSL_SYNC_CHAR 8'h80

`endif

// ==== verification/dsl_host.sv ====
// Host model on the shared debug line
`timescale 1ns/1ps
module dsl_host #(parameter int BIT_NS = 320) (
  // Shared line
  input wire logic line,
  output logic pull
);
  initial pull = 1'b0;
  task automatic send(input logic [7:0] b, input logic stop_hi);
    pull <= 1'b1;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      pull <= ~b[i];
      #(BIT_NS);
    end
    pull <= ~stop_hi;
    #(BIT_NS * 3 / 2);
    pull <= 1'b0;
    #(BIT_NS);
  endtask
  task automatic hold_low(input int bits);
    pull <= 1'b1;
    #(BIT_NS * bits);
    pull <= 1'b0;
  endtask
  task automatic recv(output logic [8:0] r);
    @(negedge line);
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 9; i++) begin
      r[i] = line;
      #(BIT_NS);
    end
  endtask
endmodule

// ==== verification/dsl_link_asserts.sv ====
// Checker for the debug serial link ports
`timescale 1ns/1ps
module dsl_link_chk (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Debug pin
  input wire debug_serial_pin_in,
  input wire debug_serial_pin_out,
  input wire debug_serial_pin_oe,
  // Streams
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready,
  // Status
  input wire stop_mode,
  input wire locked,
  input wire cmd_abort,
  input wire sys_reset_req,
  input wire break_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----
  // Helpers
  // ----
  logic [12:0] oe_run_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) oe_run_r <= 13'h0000;
    else if (!debug_serial_pin_oe) oe_run_r <= 13'h0000;
    else if (oe_run_r != 13'h1fff) oe_run_r <= oe_run_r + 13'h0001;
  end
  sequence s_stop_low;
    (stop_mode && !debug_serial_pin_in) [*5];
  endsequence
  sequence s_rx_stall;
    rx_valid && !rx_ready;
  endsequence
  // ----
  // Assertions
  // ----
  AST_PIN_OUT_LOW: assert property (!debug_serial_pin_out)
    else $error("Pin output not low");
  AST_IDLE_UNLOCKED: assert property (!locked && !$past(locked) && !break_active && !$past(break_active)
    |-> !debug_serial_pin_oe) else $error("Line driven while idle");
  AST_TX_NEEDS_LOCK: assert property (tx_ready |-> $past(locked) && $past(tx_valid))
    else $error("Byte taken while unlocked");
  AST_TX_START: assert property (tx_ready |-> debug_serial_pin_oe)
    else $error("No start bit");
  AST_ABORT_BREAK: assert property (cmd_abort |-> ##[0:2] (break_active && debug_serial_pin_oe))
    else $error("Abort without break");
  AST_BREAK_LEN: assert property ($fell(debug_serial_pin_oe) && break_active |-> oe_run_r >= 13'h00a0)
    else $error("Returned break too short");
  AST_STOP_RESET: assert property (s_stop_low |-> sys_reset_req)
    else $error("No system reset");
  AST_RESET_CAUSE: assert property (sys_reset_req |-> $past(stop_mode))
    else $error("Reset outside stop");
  AST_NO_RX_IN_BREAK: assert property (break_active && $past(break_active) |-> !$rose(rx_valid))
    else $error("Byte during break");
  AST_RX_HOLD: assert property (s_rx_stall |=> rx_valid && $stable(rx_data))
    else $error("Byte lost in stall");
endmodule

// ==== verification/tb_dsl_link.sv ====
// Self-checking bench for the debug serial link
`timescale 1ns/1ps
module tb_dsl_link;
  localparam int BIT_NS = 320;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic stop_mode = 1'b0;
  wire debug_serial_pin_out, debug_serial_pin_oe, rx_valid, tx_ready, locked, cmd_abort, sys_reset_req, break_active;
  wire [7:0] rx_data;
  wire host_pull;
  wire line = ~(host_pull | (debug_serial_pin_oe & ~debug_serial_pin_out));
  int fail_count = 0;
  int n_compared = 0;
  logic [8:0] got;
  int n;
  always #10 core_clk = ~core_clk;
  dsl_link uut (.core_clk, .rstn, .debug_serial_pin_in(line), .debug_serial_pin_out, .debug_serial_pin_oe,
    .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .stop_mode, .locked, .cmd_abort,
    .sys_reset_req, .break_active);
  dsl_host #(.BIT_NS(BIT_NS)) host (.line(line), .pull(host_pull));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic sync();
    @(posedge core_clk);
    host.send(8'h80, 1'b1);
    for (int i = 0; i < 200 && locked !== 1'b1; i++) @(posedge core_clk);
    check("locked", {8'h00, locked}, 9'h001);
  endtask
  task automatic take();
    @(posedge core_clk);
    rx_ready <= 1'b1;
    @(posedge core_clk);
    rx_ready <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge core_clk);
    tx_valid <= 1'b1;
    tx_data <= b;
    for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) @(posedge core_clk);
    tx_valid <= 1'b0;
  endtask
  task automatic expect_abort(input string what);
    for (n = 0; n < 1000 && cmd_abort !== 1'b1; n++) @(posedge core_clk);
    check(what, {8'h00, cmd_abort}, 9'h001);
    repeat (3) @(posedge core_clk);
    check("abort state", {7'h00, break_active, locked}, 9'h003);
    for (n = 0; n < 50 && debug_serial_pin_oe !== 1'b1; n++) @(posedge core_clk);
    for (n = 0; n < 2000 && debug_serial_pin_oe === 1'b1; n++) @(posedge core_clk);
    check("break bits", 9'((n + 8) / 16), 9'h028);
    for (n = 0; n < 2000 && break_active !== 1'b0; n++) @(posedge core_clk);
    check("break end", {7'h00, break_active, locked}, 9'h000);
    sync();
  endtask
  task automatic t_idle();
    tx_valid <= 1'b1;
    n = 0;
    repeat (50) begin
      @(posedge core_clk);
      if (debug_serial_pin_oe !== 1'b0 || tx_ready !== 1'b0) n++;
    end
    tx_valid <= 1'b0;
    check("idle drive", 9'(n), 9'h000);
  endtask
  task automatic t_rx();
    host.send(8'ha5, 1'b1);
    host.send(8'h3c, 1'b1);
    check("rx first", {rx_valid, rx_data}, 9'h1a5);
    take();
    check("rx second", {rx_valid, rx_data}, 9'h13c);
    take();
    check("rx empty", {8'h00, rx_valid}, 9'h000);
  endtask
  task automatic t_tx();
    fork
      put(8'h5a);
      host.recv(got);
    join
    check("tx char", got, 9'h15a);
  endtask
  task automatic t_stop();
    stop_mode <= 1'b1;
    repeat (10) @(posedge core_clk);
    check("no stop reset", {8'h00, sys_reset_req}, 9'h000);
    fork
      host.hold_low(2);
      begin
        repeat (10) @(posedge core_clk);
        check("stop reset", {8'h00, sys_reset_req}, 9'h001);
      end
    join
    stop_mode <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_idle();
    sync();
    t_rx();
    t_tx();
    fork
      put(8'hff);
      begin
        @(negedge line);
        #(BIT_NS * 3);
        host.hold_low(2);
      end
      expect_abort("collision abort");
    join
    fork
      host.send(8'h11, 1'b0);
      expect_abort("frame abort");
    join
    fork
      host.hold_low(12);
      expect_abort("break abort");
    join
    t_stop();
    end_of_test();
  end
  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end
endmodule
bind dsl_link dsl_link_chk chk (.core_clk, .rstn, .debug_serial_pin_in, .debug_serial_pin_out, .debug_serial_pin_oe,
  .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .stop_mode, .locked, .cmd_abort,
  .sys_reset_req, .break_active);

// ==== verilog/dsl_link.v ====
// Debug serial autobaud link: open-drain half-duplex front end
// Functional notes
// - Frame is low start, eight data LSB first, one and a half stop bits high.
// - After reset stay idle and send nothing until host sends a character.
// - Count clocks over eight low bits; set rx and tx bit rate.
// - Counters run on system clock, wide enough for clock divided by 512.
// - Nine or more low bit times is a break; relock on next 0x80.
// - Low sampled stop bit flags framing error.
// - Detect collision when host drives line while we transmit.
// - On any error abort command, send four-character break, reset baud detect.
// - Open-drain line; returned break only extends an early released host break.
// - Host break does not clear debug control state or leave debug mode.
// - Serial logic held in reset during break until line returns high.
// - Line low during stop state starts full system reset.
`timescale 1ns/1ps
`include "dsl_consts.vh"

module dsl_link #(
  parameter MEAS_W = `DSL_MEAS_W,
  parameter BIT_W = `DSL_BIT_W
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Debug pin, open drain
  input wire debug_serial_pin_in,
  output reg debug_serial_pin_out,
  output reg debug_serial_pin_oe,
  // Received bytes
  output reg rx_valid,
  output reg [7:0] rx_data,
  input wire rx_ready,
  // Bytes to transmit
  input wire tx_valid,
  input wire [7:0] tx_data,
  output reg tx_ready,
  // Status
  input wire stop_mode,
  output reg locked,
  output reg cmd_abort,
  output reg sys_reset_req,
  output reg break_active
);

  localparam ST_IDLE = 3'd0;
  localparam ST_MEAS = 3'd1;
  localparam ST_WAITHI = 3'd2;
  localparam ST_READY = 3'd3;
  localparam ST_RX = 3'd4;
  localparam ST_TX = 3'd5;
  localparam ST_BRKTX = 3'd6;
  localparam ST_HOLD = 3'd7;
  localparam [MEAS_W-1:0] BRK_BITS = `DSL_BREAK_BITS;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  reg pin_s1_r;
  reg pin_r;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 1'b1;
      pin_r <= 1'b1;
    end else begin
      pin_s1_r <= debug_serial_pin_in;
      pin_r <= pin_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Two-entry receive buffer
  // ---------------------------------------------------------------
  reg [7:0] buf_mem [0:1];
  reg buf_wp_r;
  reg buf_rp_r;
  reg [1:0] buf_cnt_r;
  reg rx_push;
  reg [7:0] rx_push_data;
  wire buf_full = (buf_cnt_r == 2'd2);
  wire out_take = rx_valid && rx_ready;
  wire buf_pop = (buf_cnt_r != 2'd0) && (!rx_valid || out_take);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'd0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (rx_push && !buf_full) begin
        buf_mem[buf_wp_r] <= rx_push_data;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_pop) begin
        rx_data <= buf_mem[buf_rp_r];
        buf_rp_r <= ~buf_rp_r;
        rx_valid <= 1'b1;
      end else if (out_take) begin
        rx_valid <= 1'b0;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, rx_push && !buf_full} - {1'b0, buf_pop};
    end
  end

  // ---------------------------------------------------------------
  // Main sequencer
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg [BIT_W-1:0] bit_per_r;
  reg [MEAS_W-1:0] cnt_r;
  reg [MEAS_W-1:0] low_r;
  reg [5:0] bit_idx_r;
  reg [8:0] shift_r;
  reg tx_bit_r;
  reg [MEAS_W-1:0] break_len;

  function [MEAS_W-1:0] half_of;
    input [BIT_W-1:0] p;
    begin
      half_of = {{(MEAS_W-BIT_W+1){1'b0}}, p[BIT_W-1:1]};
    end
  endfunction

  always @* begin
    break_len = {{(MEAS_W-BIT_W){1'b0}}, bit_per_r} * BRK_BITS;
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      bit_per_r <= {BIT_W{1'b0}};
      cnt_r <= {MEAS_W{1'b0}};
      low_r <= {MEAS_W{1'b0}};
      bit_idx_r <= 6'd0;
      shift_r <= 9'h000;
      tx_bit_r <= 1'b1;
      debug_serial_pin_out <= 1'b0;
      debug_serial_pin_oe <= 1'b0;
      tx_ready <= 1'b0;
      locked <= 1'b0;
      cmd_abort <= 1'b0;
      sys_reset_req <= 1'b0;
      break_active <= 1'b0;
      rx_push <= 1'b0;
      rx_push_data <= 8'h00;
    end else begin
      rx_push <= 1'b0;
      cmd_abort <= 1'b0;
      tx_ready <= 1'b0;
      debug_serial_pin_out <= 1'b0;
      sys_reset_req <= stop_mode && !pin_r;
      if (locked && !pin_r && state_r != ST_BRKTX && state_r != ST_HOLD) begin
        low_r <= low_r + 1'b1;
      end else if (pin_r) begin
        low_r <= {MEAS_W{1'b0}};
      end
      if (locked && low_r >= break_len && state_r != ST_BRKTX && state_r != ST_HOLD) begin
        cmd_abort <= 1'b1;
        state_r <= ST_BRKTX;
        cnt_r <= {MEAS_W{1'b0}};
        bit_idx_r <= 6'd0;
        debug_serial_pin_oe <= 1'b1;
        break_active <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            debug_serial_pin_oe <= 1'b0;
            locked <= 1'b0;
            cnt_r <= {MEAS_W{1'b0}};
            if (!pin_r) begin
              // First low cycle counts too
              cnt_r <= {{(MEAS_W-1){1'b0}}, 1'b1};
              state_r <= ST_MEAS;
            end
          end
          ST_MEAS: begin
            if (pin_r) begin
              bit_per_r <= cnt_r[BIT_W+2:3];
              state_r <= ST_WAITHI;
              cnt_r <= {MEAS_W{1'b0}};
            end else if (cnt_r == {MEAS_W{1'b1}}) begin
              state_r <= ST_HOLD;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          // Let the remainder of the sync character pass
          ST_WAITHI: begin
            cnt_r <= cnt_r + 1'b1;
            if (!pin_r) begin
              cnt_r <= {MEAS_W{1'b0}};
            end else if (cnt_r >= {3'd0, bit_per_r} * 2'd2) begin
              locked <= 1'b1;
              state_r <= ST_READY;
            end
          end
          ST_READY: begin
            cnt_r <= {MEAS_W{1'b0}};
            bit_idx_r <= 6'd0;
            if (!pin_r) begin
              state_r <= ST_RX;
            end else if (tx_valid && !tx_ready) begin
              tx_ready <= 1'b1;
              shift_r <= {tx_data, 1'b0};
              tx_bit_r <= 1'b0;
              debug_serial_pin_oe <= 1'b1;
              state_r <= ST_TX;
            end
          end
          ST_RX: begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == half_of(bit_per_r) + {3'd0, bit_per_r} * bit_idx_r) begin
              bit_idx_r <= bit_idx_r + 1'b1;
              if (bit_idx_r == 6'd0 && pin_r) begin
                state_r <= ST_READY;
              end else if (bit_idx_r >= 6'd1 && bit_idx_r <= 6'd8) begin
                shift_r <= {pin_r, shift_r[8:1]};
              end else if (bit_idx_r == 6'd9) begin
                if (!pin_r) begin
                  cmd_abort <= 1'b1;
                  state_r <= ST_BRKTX;
                  cnt_r <= {MEAS_W{1'b0}};
                  bit_idx_r <= 6'd0;
                  debug_serial_pin_oe <= 1'b1;
                  break_active <= 1'b1;
                end else begin
                  rx_push <= 1'b1;
                  rx_push_data <= shift_r[8:1];
                  state_r <= ST_READY;
                end
              end
            end
          end
          // start, data, 1.5 stop; collision check
          ST_TX: begin
            cnt_r <= cnt_r + 1'b1;
            debug_serial_pin_oe <= !tx_bit_r;
            if (tx_bit_r && !pin_r && cnt_r == half_of(bit_per_r)) begin
              cmd_abort <= 1'b1;
              state_r <= ST_BRKTX;
              cnt_r <= {MEAS_W{1'b0}};
              bit_idx_r <= 6'd0;
              debug_serial_pin_oe <= 1'b1;
              break_active <= 1'b1;
            end else if ((bit_idx_r < 6'd9 && cnt_r + 1'b1 >= {3'd0, bit_per_r}) ||
                         (bit_idx_r == 6'd9 && cnt_r + 1'b1 >= {3'd0, bit_per_r} + half_of(bit_per_r))) begin
              cnt_r <= {MEAS_W{1'b0}};
              bit_idx_r <= bit_idx_r + 1'b1;
              if (bit_idx_r == 6'd9) begin
                debug_serial_pin_oe <= 1'b0;
                state_r <= ST_READY;
              end else begin
                tx_bit_r <= (bit_idx_r == 6'd8) ? 1'b1 : shift_r[1];
                debug_serial_pin_oe <= (bit_idx_r == 6'd8) ? 1'b0 : !shift_r[1];
                shift_r <= {1'b1, shift_r[8:1]};
              end
            end
          end
          ST_BRKTX: begin
            debug_serial_pin_oe <= 1'b1;
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r + 1'b1 >= {3'd0, bit_per_r}) begin
              cnt_r <= {MEAS_W{1'b0}};
              bit_idx_r <= bit_idx_r + 1'b1;
              if (bit_idx_r == `DSL_BREAK_CHARS * `DSL_CHAR_BITS - 1) begin
                debug_serial_pin_oe <= 1'b0;
                state_r <= ST_HOLD;
              end
            end
          end
          // held until line high; no control state touched
          ST_HOLD: begin
            debug_serial_pin_oe <= 1'b0;
            locked <= 1'b0;
            if (pin_r) begin
              break_active <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule
